/* File: logic/scpisr_status.sv */
// Status byte and questionable register group with command port
`timescale 1ns/1ps

module scpisr_status
    import scpisr_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Monitored instrument state, same clock domain
    input  wire scpisr_mon_t mon,
    // Status command port
    input  wire scpisr_cmd_t cmd,
    output scpisr_rsp_t      rsp,
    // Status byte and service request
    output logic [7:0]       status_summary_byte,
    output logic             srq
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] questionable_event;
    logic [15:0] questionable_enable;
    logic [15:0] questionable_rising_filter;
    logic [15:0] questionable_falling_filter;
    logic [15:0] prev_cond;
    logic [7:0]  sre;

    logic [15:0] next_event;
    logic [15:0] next_enable;
    logic [15:0] next_rising;
    logic [15:0] next_falling;
    logic [7:0]  next_sre;
    logic [7:0]  next_stb;
    logic        next_srq;
    scpisr_rsp_t next_rsp;

    logic [15:0] cond;
    logic [15:0] hits;
    logic [7:0]  base;
    logic        clr_ev;

    // ------------------------------------------------------------
    // Condition and transition detection
    // ------------------------------------------------------------
    // Undefined condition bits are tied low
    always_comb begin
        cond          = 16'h0000;
        cond[QB_PROT] = mon.prot_off;
        cond[QB_FREQ] = mon.freq_invalid;
        cond[QB_SEQ]  = mon.seq_error;
    end

    // Only enabled edge directions raise a hit
    assign hits = (cond & ~prev_cond & questionable_rising_filter)
                | (~cond & prev_cond & questionable_falling_filter);

    // ------------------------------------------------------------
    // Next-state computation
    // ------------------------------------------------------------
    // Set wins over clear so an edge in a clearing cycle is kept
    always_comb begin
        next_enable  = questionable_enable;
        next_rising  = questionable_rising_filter;
        next_falling = questionable_falling_filter;
        next_sre     = sre;
        next_rsp     = '0;
        clr_ev       = 1'b0;
        if (cmd.valid) begin
            next_rsp.valid = 1'b1;
            case (cmd.op)
                CMD_RD_STB:   next_rsp.data = {8'h00, status_summary_byte};
                CMD_RD_SRE:   next_rsp.data = {8'h00, sre};
                CMD_WR_SRE:   next_sre      = cmd.data[7:0];
                CMD_RD_QCOND: next_rsp.data = cond;
                CMD_RD_QEVEN: begin
                    next_rsp.data = questionable_event;
                    clr_ev        = 1'b1;
                end
                CMD_RD_QENAB: next_rsp.data = questionable_enable;
                CMD_WR_QENAB: next_enable   = cmd.data;
                CMD_RD_QNTR:  next_rsp.data = questionable_falling_filter;
                CMD_WR_QNTR:  next_falling  = cmd.data;
                CMD_RD_QPTR:  next_rsp.data = questionable_rising_filter;
                CMD_WR_QPTR:  next_rising   = cmd.data;
                CMD_CLS:      clr_ev        = 1'b1;
                CMD_PRES: begin
                    clr_ev       = 1'b1;
                    next_enable  = QEN_RST;
                    next_rising  = QRISE_RST;
                    next_falling = QFALL_RST;
                end
                default:      next_rsp.data = 16'h0000;
            endcase
        end
        next_event = (clr_ev ? QEV_RST : questionable_event)
                   | hits;
    end

    // Status bits selected for service, master summary bit excluded
    function automatic logic [7:0] srq_sel(input logic [7:0] bits,
                                           input logic [7:0] mask);
        return bits & mask & SB_NO_MSS;
    endfunction

    // Summary built from next values so it tracks in the same edge
    always_comb begin
        base          = 8'h00;
        base[SB_ERRQ] = mon.err_queue;
        base[SB_QUES] = |(next_event & next_enable);
        base[SB_MAV]  = mon.msg_avail;
        base[SB_ESB]  = mon.std_event;
        base[SB_OPER] = mon.oper_sum;
        next_stb          = base;
        next_stb[SB_MSS]  = |srq_sel(base, next_sre);
        // Request only on a fresh rise of a selected bit
        next_srq = |(srq_sel(base, next_sre)
                     & ~status_summary_byte);
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            questionable_event          <= QEV_RST;
            questionable_enable         <= QEN_RST;
            questionable_rising_filter  <= QRISE_RST;
            questionable_falling_filter <= QFALL_RST;
            prev_cond                   <= 16'h0000;
            sre                         <= SRE_RST;
            status_summary_byte         <= SB_RST;
            srq                         <= 1'b0;
            rsp                         <= '0;
        end else begin
            questionable_event          <= next_event;
            questionable_enable         <= next_enable;
            questionable_rising_filter  <= next_rising;
            questionable_falling_filter <= next_falling;
            prev_cond                   <= cond;
            sre                         <= next_sre;
            status_summary_byte         <= next_stb;
            srq                         <= next_srq;
            rsp                         <= next_rsp;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_query(scpisr_op_t o);
        cmd.valid && cmd.op == o;
    endsequence

    sequence s_answer;
        rsp.valid;
    endsequence

    property p_cond_read;
        s_query(CMD_RD_QCOND) |=> s_answer and rsp.data == $past(cond);
    endproperty
    a_cond_read: assert property (p_cond_read)
        else $error("condition query answer wrong");

    property p_event_read;
        s_query(CMD_RD_QEVEN) |=> s_answer
            and rsp.data == $past(questionable_event)
            and questionable_event == $past(hits);
    endproperty
    a_event_read: assert property (p_event_read)
        else $error("event query did not clear or answer");

    property p_event_set;
        hits != 16'h0000 |=> (questionable_event & $past(hits))
                             == $past(hits);
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("event bit not latched");

    property p_event_cause;
        1'b1 |=> (questionable_event & ~$past(questionable_event)
                  & ~$past(hits)) == 16'h0000;
    endproperty
    a_event_cause: assert property (p_event_cause)
        else $error("event bit set without filtered edge");

    property p_cls;
        s_query(CMD_CLS) |=> questionable_enable
            == $past(questionable_enable)
            and questionable_rising_filter
            == $past(questionable_rising_filter)
            and questionable_event == $past(hits);
    endproperty
    a_cls: assert property (p_cls)
        else $error("clear status touched enable or filter");

    property p_pres;
        s_query(CMD_PRES) |=> questionable_enable == 16'h0000
            and questionable_rising_filter == 16'hFFFF
            and questionable_falling_filter == 16'h0000;
    endproperty
    a_pres: assert property (p_pres)
        else $error("preset values wrong");

    property p_ques_sum;
        status_summary_byte[SB_QUES]
            == |(questionable_event & questionable_enable);
    endproperty
    a_ques_sum: assert property (p_ques_sum)
        else $error("questionable summary mismatch");

    property p_mss;
        status_summary_byte[SB_MSS]
            == |(status_summary_byte & sre & SB_NO_MSS)
            and status_summary_byte[1:0] == 2'b00;
    endproperty
    a_mss: assert property (p_mss)
        else $error("master summary or low bits wrong");

    property p_mav;
        1'b1 |=> status_summary_byte[SB_MAV] == $past(mon.msg_avail)
            and status_summary_byte[SB_ERRQ] == $past(mon.err_queue);
    endproperty
    a_mav: assert property (p_mav)
        else $error("message or error bit lag");

    property p_srq;
        srq |-> $past(|(status_summary_byte & SB_NO_MSS & sre)) == 1'b0
            or $past(status_summary_byte) != status_summary_byte;
    endproperty
    a_srq: assert property (p_srq)
        else $error("service request without rising bit");

    // No command, no answer: the port stays quiet
    property p_rsp_idle;
        !cmd.valid |=> !rsp.valid && rsp.data == 16'h0000;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle)
        else $error("answer without command");

    // Filters move only on their own writes or a preset
    property p_filter_hold;
        !(cmd.valid && (cmd.op == CMD_WR_QPTR || cmd.op == CMD_WR_QNTR
                        || cmd.op == CMD_PRES))
            |=> (questionable_rising_filter
                 == $past(questionable_rising_filter))
             && (questionable_falling_filter
                 == $past(questionable_falling_filter));
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("transition filter changed without a write");

    // Enable survives clear-status and every read
    property p_enable_hold;
        !(cmd.valid && (cmd.op == CMD_WR_QENAB || cmd.op == CMD_PRES))
            |=> questionable_enable == $past(questionable_enable);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("enable register changed without a write");

    // Event bits never drop outside a clearing command
    property p_event_hold;
        !(cmd.valid && (cmd.op == CMD_RD_QEVEN || cmd.op == CMD_CLS
                        || cmd.op == CMD_PRES))
            |=> (questionable_event & $past(questionable_event))
                == $past(questionable_event);
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event bit dropped without a clear");

    // Service enable takes the low byte of the write
    property p_sre_write;
        s_query(CMD_WR_SRE) |=> s_answer and sre == $past(cmd.data[7:0]);
    endproperty
    a_sre_write: assert property (p_sre_write)
        else $error("service enable write lost");

endmodule

/* File: logic/scpisr_pkg.sv */
// Constants, commands and carriers of the status-reporting block
package scpisr_pkg;

    // ------------------------------------------------------------
    // Questionable group field positions and reset values
    // ------------------------------------------------------------
    localparam int          QB_PROT        = 0;
    localparam int          QB_FREQ        = 5;
    localparam int          QB_SEQ         = 10;
    localparam logic [15:0] QEV_RST        = 16'h0000;
    localparam logic [15:0] QEN_RST        = 16'h0000;
    localparam logic [15:0] QRISE_RST      = 16'hFFFF;
    localparam logic [15:0] QFALL_RST      = 16'h0000;

    // ------------------------------------------------------------
    // Status byte field positions and reset values
    // ------------------------------------------------------------
    localparam int          SB_ERRQ        = 2;
    localparam int          SB_QUES        = 3;
    localparam int          SB_MAV         = 4;
    localparam int          SB_ESB         = 5;
    localparam int          SB_MSS         = 6;
    localparam int          SB_OPER        = 7;
    localparam logic [7:0]  SB_RST         = 8'h00;
    localparam logic [7:0]  SRE_RST        = 8'h00;
    localparam logic [7:0]  SB_NO_MSS      = 8'hBF;

    // ------------------------------------------------------------
    // Status commands and carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_RD_STB   = 4'h0,
        CMD_RD_SRE   = 4'h1,
        CMD_WR_SRE   = 4'h2,
        CMD_RD_QCOND = 4'h3,
        CMD_RD_QEVEN = 4'h4,
        CMD_RD_QENAB = 4'h5,
        CMD_WR_QENAB = 4'h6,
        CMD_RD_QNTR  = 4'h7,
        CMD_WR_QNTR  = 4'h8,
        CMD_RD_QPTR  = 4'h9,
        CMD_WR_QPTR  = 4'hA,
        CMD_CLS      = 4'hB,
        CMD_PRES     = 4'hC
    } scpisr_op_t;

    typedef struct packed {
        logic        valid;
        scpisr_op_t  op;
        logic [15:0] data;
    } scpisr_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } scpisr_rsp_t;

    typedef struct packed {
        logic prot_off;
        logic freq_invalid;
        logic seq_error;
        logic err_queue;
        logic msg_avail;
        logic std_event;
        logic oper_sum;
    } scpisr_mon_t;

endpackage

/* File: tb/scpisr_host.sv */
// Controller model issuing status commands and collecting answers
`timescale 1ns/1ps

module scpisr_host
    import scpisr_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Command port towards the block
    output scpisr_cmd_t      cmd,
    input  wire scpisr_rsp_t rsp
);
    // ------------------------------------------------------------
    // Idle command port
    // ------------------------------------------------------------
    initial begin
        cmd = '0;
    end

    // One command per call; released data is inverted, not left stale
    task automatic issue(input scpisr_op_t op, input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 16'h0000;
        @(posedge sys_clk);
        cmd <= '{valid: 1'b1, op: op, data: wdata};
        @(posedge sys_clk);
        cmd <= '{valid: 1'b0, op: op, data: ~wdata};
        for (n = 0; n < 4 && !ok; n++) begin
            // Answer stands from the taking edge; read before it moves
            @(posedge sys_clk);
            if (rsp.valid === 1'b1) begin
                ok = 1'b1;
                rdata = rsp.data;
            end
        end
    endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the status-reporting block
`timescale 1ns/1ps

module testbench
    import scpisr_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        sys_clk;
    logic        arst_n;
    scpisr_mon_t mon;
    scpisr_cmd_t cmd;
    scpisr_rsp_t rsp;
    logic [7:0]  stb;
    logic        srq;
    int          errors;
    int          check_count;

    scpisr_status dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .mon(mon),
        .cmd(cmd), .rsp(rsp), .status_summary_byte(stb), .srq(srq));
    scpisr_host host_u (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // Command plus answer compare; a lost answer ends the run
    task automatic rd(input scpisr_op_t op, input logic [15:0] wd,
                      input logic [15:0] exp, input string what);
        logic [15:0] got;
        logic        ok;
        host_u.issue(op, wd, got, ok);
        if (!ok) begin
            errors++;
            $display("mismatch at %0t: no answer to %s", $time, what);
            test_done();
        end else begin
            chk(got, exp, what);
        end
    endtask

    task automatic setmon(input scpisr_mon_t v);
        @(posedge sys_clk);
        mon <= v;
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rd(CMD_RD_QPTR, 16'h0000, 16'hFFFF, "ptr rst");
        rd(CMD_RD_QNTR, 16'h0000, 16'h0000, "ntr rst");
        rd(CMD_RD_QENAB, 16'h0000, 16'h0000, "enab rst");
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0000, "even rst");
        rd(CMD_RD_STB, 16'h0000, 16'h0000, "stb rst");
        rd(scpisr_op_t'(4'hF), 16'h1234, 16'h0000, "bad op");
        $display("test reset done");
    endtask

    task automatic test_rise();
        setmon('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
        rd(CMD_RD_QCOND, 16'h0000, 16'h0421, "cond");
        rd(CMD_RD_QCOND, 16'h0000, 16'h0421, "cond again");
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0421, "rise evt");
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0000, "read clr");
        $display("test rise done");
    endtask

    task automatic test_fall();
        rd(CMD_WR_QPTR, 16'h0000, 16'h0000, "wr ptr");
        rd(CMD_WR_QNTR, 16'hFFFF, 16'h0000, "wr ntr");
        setmon('0);
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0421, "fall evt");
        setmon('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0000, "rise masked");
        rd(CMD_RD_QPTR, 16'h0000, 16'h0000, "ptr rd");
        $display("test fall done");
    endtask

    task automatic test_mask();
        rd(CMD_WR_QPTR, 16'hFFFF, 16'h0000, "wr ptr");
        rd(CMD_WR_QNTR, 16'h0000, 16'h0000, "wr ntr");
        setmon('0);
        setmon('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
        rd(CMD_WR_QENAB, 16'h0020, 16'h0000, "enab other");
        rd(CMD_RD_STB, 16'h0000, 16'h0000, "masked");
        rd(CMD_WR_QENAB, 16'h0001, 16'h0000, "enab bit0");
        rd(CMD_RD_STB, 16'h0000, 16'h0008, "ques sum");
        rd(CMD_CLS, 16'h0000, 16'h0000, "cls");
        rd(CMD_RD_STB, 16'h0000, 16'h0000, "sum clr");
        rd(CMD_RD_QENAB, 16'h0000, 16'h0001, "enab kept");
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0000, "evt clr");
        rd(CMD_RD_QPTR, 16'h0000, 16'hFFFF, "ptr kept");
        $display("test mask done");
    endtask

    // One service pulse when the selected bit rises in the same cycle as unselected ones
    task automatic test_summary();
        int hi;
        hi = 0;
        rd(CMD_WR_SRE, 16'h0010, 16'h0000, "wr sre");
        setmon('{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1});
        for (int n = 0; n < 6; n++) begin
            @(posedge sys_clk);
            #1;
            if (srq === 1'b1) begin
                hi++;
            end
        end
        chk(16'(hi), 16'h0001, "srq");
        rd(CMD_RD_STB, 16'h0000, 16'h00F4, "stb");
        rd(CMD_RD_STB, 16'h0000, 16'h00F4, "stb again");
        #1;
        chk({8'h00, stb}, 16'h00F4, "stb pin");
        rd(CMD_RD_SRE, 16'h0000, 16'h0010, "sre rd");
        setmon('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1});
        rd(CMD_RD_STB, 16'h0000, 16'h00A4, "msg gone");
        $display("test summary done");
    endtask

    task automatic test_preset();
        rd(CMD_WR_QENAB, 16'h0400, 16'h0000, "wr enab");
        rd(CMD_WR_QPTR, 16'h0000, 16'h0000, "wr ptr");
        rd(CMD_WR_QNTR, 16'h00FF, 16'h0000, "wr ntr");
        setmon('0);
        rd(CMD_PRES, 16'h0000, 16'h0000, "pres");
        rd(CMD_RD_QENAB, 16'h0000, 16'h0000, "enab pres");
        rd(CMD_RD_QPTR, 16'h0000, 16'hFFFF, "ptr pres");
        rd(CMD_RD_QNTR, 16'h0000, 16'h0000, "ntr pres");
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0000, "evt pres");
        $display("test preset done");
    endtask

    // Edge lands in the same cycle as a clearing read and survives it
    task automatic test_overlap();
        logic [15:0] got;
        logic        ok;
        fork
            host_u.issue(CMD_RD_QEVEN, 16'h0000, got, ok);
            setmon('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
        join
        chk({15'h0000, ok}, 16'h0001, "overlap answer");
        chk(got, 16'h0000, "overlap old");
        rd(CMD_RD_QEVEN, 16'h0000, 16'h0001, "overlap kept");
        $display("test overlap done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        check_count = 0;
        arst_n = 1'b0;
        mon = '0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        test_reset();
        test_rise();
        test_fall();
        test_mask();
        test_summary();
        test_preset();
        test_overlap();
        test_done();
    end
endmodule
